// >>> design/flic_pkg.sv
// flic_pkg: shared constants and types of the four level interrupt controller
// assumes one 40 MHz clock where one clock is one machine cycle of the core
package flic_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] REQ_TWO_IDX = 8'h97;
  localparam logic [7:0] EN_THREE_IDX = 8'h9A;
  localparam logic [7:0] EN_ONE_IDX = 8'hA8;
  localparam logic [7:0] PRIO_LO_IDX = 8'hA9;
  localparam logic [7:0] EN_TWO_IDX = 8'hB8;
  localparam logic [7:0] PRIO_HI_IDX = 8'hB9;
  localparam logic [7:0] REQ_ONE_IDX = 8'hC0;

  // implemented bits of each register; the rest read as zero
  localparam logic [7:0] EN_ONE_MASK = 8'hBF;
  localparam logic [7:0] EN_TWO_MASK = 8'hB5;
  localparam logic [7:0] EN_THREE_MASK = 8'h0A;
  localparam logic [7:0] REQ_ONE_MASK = 8'hF5;
  localparam logic [7:0] REQ_TWO_MASK = 8'h0A;
  localparam logic [7:0] PRIO_MASK = 8'h3F;
  localparam logic [7:0] REG_RESET = 8'h00;

  // bit positions
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PIN0_EN_BIT = 0;
  localparam int TMR0_EN_BIT = 1;
  localparam int PIN1_EN_BIT = 2;
  localparam int TMR1_EN_BIT = 3;
  localparam int SERIAL_EN_BIT = 4;
  localparam int TMR2_EN_BIT = 5;
  localparam int TMR2_RELOAD_BIT = 7;
  localparam int TMR2_OVF_BIT = 6;
  localparam int TWOWIRE_BIT = 5;
  localparam int LOW_VOLT_BIT = 4;
  localparam int CONVERTER_BIT = 2;
  localparam int PULSE_WIDTH_BIT = 0;
  localparam int TOUCH_BIT = 3;
  localparam int WATCHDOG_BIT = 1;

  // sources, numbered in polling order
  localparam int NUM_SRC = 12;
  localparam int NUM_GROUP = 6;
  localparam logic [3:0] SRC_PIN0 = 4'h0;
  localparam logic [3:0] SRC_PWM = 4'h1;
  localparam logic [3:0] SRC_TMR0 = 4'h2;
  localparam logic [3:0] SRC_WDOG = 4'h3;
  localparam logic [3:0] SRC_PIN1 = 4'h4;
  localparam logic [3:0] SRC_CONV = 4'h5;
  localparam logic [3:0] SRC_TMR1 = 4'h6;
  localparam logic [3:0] SRC_SERIAL = 4'h7;
  localparam logic [3:0] SRC_LOWV = 4'h8;
  localparam logic [3:0] SRC_TOUCH = 4'h9;
  localparam logic [3:0] SRC_TMR2 = 4'hA;
  localparam logic [3:0] SRC_TWOWIRE = 4'hB;

  // group of each source, indexed by source number
  localparam logic [2:0] SRC_GROUP [NUM_SRC] = '{3'h0, 3'h0, 3'h1, 3'h1,
    3'h2, 3'h2, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5, 3'h5};
  // vector address of each source
  localparam logic [15:0] SRC_VECTOR [NUM_SRC] = '{16'h0003, 16'h0043,
    16'h000B, 16'h008B, 16'h0013, 16'h0053, 16'h001B, 16'h0023,
    16'h0063, 16'h009B, 16'h002B, 16'h006B};

  // fastest response of the core, in machine cycles
  localparam int FASTEST_RESPONSE_CYCLES = 7;

  typedef logic [1:0] flic_level_type;

  typedef struct packed {
    logic [7:0] enOne;
    logic [7:0] enTwo;
    logic [7:0] enThree;
    logic [7:0] prioLo;
    logic [7:0] prioHi;
    logic [7:0] reqOne;
    logic [7:0] reqTwo;
    logic [3:0] inService;
    logic irqReq;
    logic [15:0] vector;
    flic_level_type level;
    logic [3:0] source;
    logic waitReq;
    logic [31:0] readData;
  } flic_state_type;

endpackage : flic_pkg

// >>> design/flic_reset_sync.sv
// flic_reset_sync: releases the asynchronous reset through two flip-flops
// assumes arst_n may fall at any time and rises in any relation to the clock
`timescale 1ns/1ps
module flic_reset_sync (
  // clock and raw reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // reset for the rest of the design
  output logic syncRst_n
);

  logic stageOne_q;

  // the first stage feeds only the second
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stageOne_q <= 1'b0;
      syncRst_n <= 1'b0;
    end else begin
      stageOne_q <= 1'b1;
      syncRst_n <= stageOne_q;
    end
  end

endmodule : flic_reset_sync

// >>> design/flic_arbiter.sv
// flic_arbiter: picks the pending source of highest level, then polling order
// assumes pending bits are already gated by their enables; purely combinational
`timescale 1ns/1ps
module flic_arbiter
  import flic_pkg::*;
#(
  parameter int NSRC = NUM_SRC
) (
  // enabled requests and group priority bits
  input wire logic [NSRC-1:0] pending,
  input wire logic [NUM_GROUP-1:0] prioLo,
  input wire logic [NUM_GROUP-1:0] prioHi,
  // winner
  output logic found,
  output logic [3:0] winner,
  output flic_level_type winLevel
);

  // level of one source from its group bits, high bit from prioHi
  function automatic flic_level_type levelOf(input int src,
      input logic [NUM_GROUP-1:0] lo, input logic [NUM_GROUP-1:0] hi);
    levelOf = {hi[SRC_GROUP[src]], lo[SRC_GROUP[src]]};
  endfunction : levelOf

  // scan from the last source down; >= lets the earlier source win ties
  always_comb begin
    found = 1'b0;
    winner = 4'h0;
    winLevel = 2'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pending[i] && (!found || levelOf(i, prioLo, prioHi) >= winLevel)) begin
        found = 1'b1;
        winner = 4'(i);
        winLevel = levelOf(i, prioLo, prioHi);
      end
    end
  end

endmodule : flic_arbiter

// >>> design/flic_top.sv
// flic_top: four level interrupt controller with an Avalon-MM register slave
// assumes a single-cycle core that pulses irqAck on vector entry and
// retiDone when a return from interrupt completes
`timescale 1ns/1ps
module flic_top
  import flic_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // avalon-mm slave, word addressed
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // request levels whose flags live in their peripherals
  input wire logic pinIrq0Req,
  input wire logic timer0Req,
  input wire logic pinIrq1Req,
  input wire logic timer1Req,
  input wire logic serialReq,
  // one-cycle events that set flags held here
  input wire logic timer2ReloadEvt,
  input wire logic timer2OverflowEvt,
  input wire logic twowireEvt,
  input wire logic lowVoltageEvt,
  input wire logic converterDoneEvt,
  input wire logic pulseWidthEvt,
  input wire logic touchEvt,
  input wire logic watchdogEvt,
  // core handshake
  input wire logic irqAck,
  input wire logic retiDone,
  output logic irqReq,
  output logic [15:0] irqVector,
  output flic_level_type irqLevel,
  output logic [3:0] irqSource,
  output logic [3:0] inServiceLevels
);

  flic_state_type st;
  flic_state_type nx;
  logic rst_n;
  logic [NUM_SRC-1:0] pending;
  logic found;
  logic [3:0] winner;
  flic_level_type winLevel;
  logic busWrite;
  logic allow;
  logic [7:0] wrByte;

  // reset release
  flic_reset_sync u_reset_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .syncRst_n(rst_n)
  );

  // highest level now in service; valid only when any bit is set
  function automatic flic_level_type topLevel(input logic [3:0] act);
    topLevel = 2'h0;
    for (int l = 0; l < 4; l++) begin
      if (act[l]) begin
        topLevel = 2'(l);
      end
    end
  endfunction : topLevel

  // read mux; unmapped indices read as zero
  function automatic logic [7:0] regRead(input logic [7:0] idx,
      input flic_state_type s);
    unique case (idx)
      EN_ONE_IDX: regRead = s.enOne;
      EN_TWO_IDX: regRead = s.enTwo;
      EN_THREE_IDX: regRead = s.enThree;
      PRIO_LO_IDX: regRead = s.prioLo;
      PRIO_HI_IDX: regRead = s.prioHi;
      REQ_ONE_IDX: regRead = s.reqOne;
      REQ_TWO_IDX: regRead = s.reqTwo;
      default: regRead = 8'h00;
    endcase
  endfunction : regRead

  // enabled requests in polling order, all gated by the global enable
  always_comb begin
    pending = '0;
    pending[SRC_PIN0] = pinIrq0Req && st.enOne[PIN0_EN_BIT];
    pending[SRC_PWM] = st.reqOne[PULSE_WIDTH_BIT] && st.enTwo[PULSE_WIDTH_BIT];
    pending[SRC_TMR0] = timer0Req && st.enOne[TMR0_EN_BIT];
    pending[SRC_WDOG] = st.reqTwo[WATCHDOG_BIT] && st.enThree[WATCHDOG_BIT];
    pending[SRC_PIN1] = pinIrq1Req && st.enOne[PIN1_EN_BIT];
    pending[SRC_CONV] = st.reqOne[CONVERTER_BIT] && st.enTwo[CONVERTER_BIT];
    pending[SRC_TMR1] = timer1Req && st.enOne[TMR1_EN_BIT];
    pending[SRC_SERIAL] = serialReq && st.enOne[SERIAL_EN_BIT];
    pending[SRC_LOWV] = st.reqOne[LOW_VOLT_BIT] && st.enTwo[LOW_VOLT_BIT];
    pending[SRC_TOUCH] = st.reqTwo[TOUCH_BIT] && st.enThree[TOUCH_BIT];
    // overflow under the timer2 enable; reload also needs its own enable
    pending[SRC_TMR2] = st.enOne[TMR2_EN_BIT] && (st.reqOne[TMR2_OVF_BIT]
      || (st.reqOne[TMR2_RELOAD_BIT] && st.enTwo[TMR2_RELOAD_BIT]));
    pending[SRC_TWOWIRE] = st.reqOne[TWOWIRE_BIT] && st.enTwo[TWOWIRE_BIT];
    if (!st.enOne[GLOBAL_EN_BIT]) begin
      pending = '0;
    end
  end

  // group and level resolution
  flic_arbiter #(
    .NSRC(NUM_SRC)
  ) u_arbiter (
    .pending(pending),
    .prioLo(st.prioLo[NUM_GROUP-1:0]),
    .prioHi(st.prioHi[NUM_GROUP-1:0]),
    .found(found),
    .winner(winner),
    .winLevel(winLevel)
  );

  // preemption needs a strictly higher level than any active service
  assign allow = (st.inService == 4'h0) || (winLevel > topLevel(st.inService));

  // a write lands at the edge where waitrequest is seen low
  assign busWrite = avs_write && !st.waitReq && avs_byteenable[0];
  assign wrByte = avs_writedata[7:0];

  // next state
  always_comb begin
    nx = st;

    // bus handshake: one wait cycle, then one cycle with waitrequest low
    if (st.waitReq) begin
      nx.waitReq = !(avs_read || avs_write);
    end else begin
      nx.waitReq = 1'b1;
    end
    if (st.waitReq && avs_read) begin
      nx.readData = {24'h000000, regRead(avs_address, st)};
    end

    // software writes; flag bits are written directly, reserved bits kept zero
    if (busWrite) begin
      unique case (avs_address)
        EN_ONE_IDX: nx.enOne = wrByte & EN_ONE_MASK;
        EN_TWO_IDX: nx.enTwo = wrByte & EN_TWO_MASK;
        EN_THREE_IDX: nx.enThree = wrByte & EN_THREE_MASK;
        PRIO_LO_IDX: nx.prioLo = wrByte & PRIO_MASK;
        PRIO_HI_IDX: nx.prioHi = wrByte & PRIO_MASK;
        REQ_ONE_IDX: nx.reqOne = wrByte & REQ_ONE_MASK;
        REQ_TWO_IDX: nx.reqTwo = wrByte & REQ_TWO_MASK;
        default: nx.enOne = st.enOne;
      endcase
    end

    // vector entry: mark the level busy, auto-clear converter and pwm
    if (irqAck && st.irqReq) begin
      nx.inService[st.level] = 1'b1;
      if (st.source == SRC_CONV) begin
        nx.reqOne[CONVERTER_BIT] = 1'b0;
      end
      if (st.source == SRC_PWM) begin
        nx.reqOne[PULSE_WIDTH_BIT] = 1'b0;
      end
    end

    // return from interrupt retires the highest active level
    if (retiDone && st.inService != 4'h0) begin
      nx.inService[topLevel(st.inService)] = 1'b0;
    end

    // events set flags last so a set beats any clear in the same cycle
    if (timer2ReloadEvt) begin
      nx.reqOne[TMR2_RELOAD_BIT] = 1'b1;
    end
    if (timer2OverflowEvt) begin
      nx.reqOne[TMR2_OVF_BIT] = 1'b1;
    end
    if (twowireEvt) begin
      nx.reqOne[TWOWIRE_BIT] = 1'b1;
    end
    if (lowVoltageEvt) begin
      nx.reqOne[LOW_VOLT_BIT] = 1'b1;
    end
    if (converterDoneEvt) begin
      nx.reqOne[CONVERTER_BIT] = 1'b1;
    end
    if (pulseWidthEvt) begin
      nx.reqOne[PULSE_WIDTH_BIT] = 1'b1;
    end
    if (touchEvt) begin
      nx.reqTwo[TOUCH_BIT] = 1'b1;
    end
    if (watchdogEvt) begin
      nx.reqTwo[WATCHDOG_BIT] = 1'b1;
    end

    // sampled every machine cycle; dropped in the ack cycle so the core
    // never sees the request it has just taken twice
    nx.irqReq = found && allow && !irqAck;
    nx.source = winner;
    nx.level = winLevel;
    nx.vector = SRC_VECTOR[winner];
  end

  // single state register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st.enOne <= REG_RESET;
      st.enTwo <= REG_RESET;
      st.enThree <= REG_RESET;
      st.prioLo <= REG_RESET;
      st.prioHi <= REG_RESET;
      st.reqOne <= REG_RESET;
      st.reqTwo <= REG_RESET;
      st.inService <= 4'h0;
      st.irqReq <= 1'b0;
      st.vector <= 16'h0000;
      st.level <= 2'h0;
      st.source <= 4'h0;
      st.waitReq <= 1'b1;
      st.readData <= 32'h00000000;
    end else begin
      st <= nx;
    end
  end

  // outputs straight from the state register
  assign avs_readdata = st.readData;
  assign avs_waitrequest = st.waitReq;
  assign irqReq = st.irqReq;
  assign irqVector = st.vector;
  assign irqLevel = st.level;
  assign irqSource = st.source;
  assign inServiceLevels = st.inService;

endmodule : flic_top

// >>> testbench/flic_top_props.sv
// flic_top_props: port timing checks for the interrupt controller
// assumes it is bound into flic_top and sees only that module's ports
`timescale 1ns/1ps
module flic_top_props
  import flic_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // core handshake
  input wire logic irqAck,
  input wire logic retiDone,
  input wire logic irqReq,
  input wire logic [15:0] irqVector,
  input wire flic_level_type irqLevel,
  input wire logic [3:0] irqSource,
  input wire logic [3:0] inServiceLevels
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // a transfer is taken while waiting and answered for exactly one cycle
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  sequence s_quiet;
    !irqReq && avs_waitrequest;
  endsequence

  a_bus_one_wait: assert property (s_taken |=> s_answer)
    else $error("bus answer not one cycle");
  a_reset_quiet: assert property ($rose(arst_n) |-> s_quiet [*3])
    else $error("activity during reset release");
  a_ack_drops_req: assert property (irqAck |=> !irqReq)
    else $error("request stayed up after acknowledge");
  a_ack_marks_level: assert property (irqAck && irqReq |=> inServiceLevels[$past(irqLevel)])
    else $error("level not marked in service");
  a_no_equal_preempt: assert property (irqReq |-> (inServiceLevels >> irqLevel) == 4'h0)
    else $error("request not above service level");
  a_reti_pops: assert property (retiDone && !irqAck && inServiceLevels != 4'h0 |=>
    $countones(inServiceLevels) == $countones($past(inServiceLevels)) - 1)
    else $error("return did not end one level");
  a_touch_vector: assert property (irqReq && irqSource == SRC_TOUCH |-> irqVector == 16'h009B)
    else $error("touch vector wrong");
  a_twowire_vector: assert property (irqReq && irqSource == SRC_TWOWIRE |-> irqVector == 16'h006B)
    else $error("two-wire vector wrong");
  a_pwm_vector: assert property (irqReq && irqSource == SRC_PWM |-> irqVector == 16'h0043)
    else $error("pulse width vector wrong");
endmodule : flic_top_props

// >>> testbench/flic_core_model.sv
// flic_core_model: behavioural core that takes vectors and returns from service
// assumes controls are driven by non-blocking assignment at rising edges
`timescale 1ns/1ps
module flic_core_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // bench controls
  input wire logic ackEnable,
  input wire logic [3:0] ackWait,
  input wire logic retiCmd,
  // controller side
  input wire logic irqReq,
  output logic irqAck,
  output logic retiDone
);
  logic [3:0] waitCnt_q;
  logic ackPulse_q;
  logic retiPulse_q;

  // a slow core lets the request stand ackWait + 1 cycles before calling the vector
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      waitCnt_q <= 4'h0;
      ackPulse_q <= 1'b0;
      retiPulse_q <= 1'b0;
    end else begin
      retiPulse_q <= retiCmd;
      ackPulse_q <= 1'b0;
      waitCnt_q <= 4'h0;
      if (irqReq && ackEnable && !ackPulse_q) begin
        ackPulse_q <= (waitCnt_q == ackWait);
        waitCnt_q <= waitCnt_q + 4'h1;
      end
    end
  end
  assign irqAck = ackPulse_q;
  assign retiDone = retiPulse_q;
endmodule : flic_core_model

// >>> testbench/flic_top_bench.sv
// flic_top_bench: directed scenarios for the interrupt controller
// assumes the core model acknowledges requests; the bench plays the peripherals
`timescale 1ns/1ps
module flic_top_bench
  import flic_pkg::*;
;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [11:0] lvl = 12'h000;
  logic [11:0] evt = 12'h000;
  logic ackEnable = 1'b1;
  logic [3:0] ackWait = 4'h0;
  logic retiCmd = 1'b0;
  logic reloadEvt = 1'b0;
  logic irqAck, retiDone, irqReq;
  logic [15:0] irqVector, q;
  flic_level_type irqLevel;
  logic [3:0] irqSource, inServiceLevels;
  int miscompares = 0;
  int checks_done = 0;
  // per source in polling order: level held by peripheral, sticky flag here
  localparam logic [11:0] LVLSRC = 12'h0D5;
  localparam logic [11:0] STICKY_ONE = 12'hD00;
  localparam logic [11:0] STICKY_TWO = 12'h208;
  localparam logic [15:0] VEC [12] = '{16'h0003, 16'h0043, 16'h000B, 16'h008B, 16'h0013, 16'h0053,
    16'h001B, 16'h0023, 16'h0063, 16'h009B, 16'h002B, 16'h006B};
  localparam logic [7:0] IDX [7] = '{REQ_TWO_IDX, EN_THREE_IDX, EN_ONE_IDX, PRIO_LO_IDX, EN_TWO_IDX,
    PRIO_HI_IDX, REQ_ONE_IDX};
  localparam logic [7:0] MSK [7] = '{REQ_TWO_MASK, EN_THREE_MASK, EN_ONE_MASK, PRIO_MASK, EN_TWO_MASK,
    PRIO_MASK, REQ_ONE_MASK};

  flic_top dut (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .pinIrq0Req(lvl[0]),
    .timer0Req(lvl[2]),
    .pinIrq1Req(lvl[4]),
    .timer1Req(lvl[6]),
    .serialReq(lvl[7]),
    .timer2ReloadEvt(reloadEvt),
    .timer2OverflowEvt(evt[10]),
    .twowireEvt(evt[11]),
    .lowVoltageEvt(evt[8]),
    .converterDoneEvt(evt[5]),
    .pulseWidthEvt(evt[1]),
    .touchEvt(evt[9]),
    .watchdogEvt(evt[3]),
    .irqAck(irqAck),
    .retiDone(retiDone),
    .irqReq(irqReq),
    .irqVector(irqVector),
    .irqLevel(irqLevel),
    .irqSource(irqSource),
    .inServiceLevels(inServiceLevels)
  );
  flic_core_model partner (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .ackEnable(ackEnable),
    .ackWait(ackWait),
    .retiCmd(retiCmd),
    .irqReq(irqReq),
    .irqAck(irqAck),
    .retiDone(retiDone)
  );

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  // one transfer; the request is held until waitrequest is seen low
  // the master counts no cycles of its own; only the watchdog ends a hung transfer
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[15:0];
    if (!wr) begin
      check(avs_readdata[31:16], 16'h0000);
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic fire(input int s);
    @(posedge ref_clk);
    if (LVLSRC[s]) lvl[s] <= 1'b1;
    else evt[s] <= 1'b1;
    @(posedge ref_clk);
    evt <= 12'h000;
  endtask : fire

  // wait for the core to take a vector, then clear the source as software would
  task automatic take(input int s, input logic [1:0] lv);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (!(irqAck === 1'b1 && irqReq === 1'b1) && n < 60);
    check({14'h0, irqAck, irqReq}, 16'h0003);
    check(irqVector, VEC[s]);
    check({10'h0, irqLevel, irqSource}, {10'h0, lv, s[3:0]});
    @(posedge ref_clk);
    lvl[s] <= 1'b0;
    if (STICKY_ONE[s]) bus(1'b1, REQ_ONE_IDX, 8'h00);
    if (STICKY_TWO[s]) bus(1'b1, REQ_TWO_IDX, 8'h00);
    if (s == 1 || s == 5) begin
      bus(1'b0, REQ_ONE_IDX, 8'h00);
      check(q & 16'h0005, 16'h0000);
    end
  endtask : take

  // nothing of equal or lower level may interrupt, then the core returns
  task automatic finish();
    repeat (3) begin
      @(negedge ref_clk);
      check({15'h0, irqReq}, 16'h0000);
    end
    @(posedge ref_clk);
    retiCmd <= 1'b1;
    @(posedge ref_clk);
    retiCmd <= 1'b0;
  endtask : finish

  task automatic t_regs();
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, IDX[i], 8'h00);
      check(q, {8'h00, REG_RESET});
      bus(1'b1, IDX[i], 8'hFF);
      bus(1'b0, IDX[i], 8'h00);
      check(q, {8'h00, MSK[i]});
      bus(1'b1, IDX[i], 8'h00);
    end
    avs_byteenable <= 4'h0;
    bus(1'b1, EN_THREE_IDX, 8'hFF);
    avs_byteenable <= 4'hF;
    bus(1'b1, 8'h00, 8'hFF);
    bus(1'b0, 8'h00, 8'h00);
    check(q, 16'h0000);
    bus(1'b0, EN_THREE_IDX, 8'h00);
    check(q, 16'h0000);
  endtask : t_regs

  task automatic t_global();
    bus(1'b1, EN_THREE_IDX, 8'h08);
    fire(9);
    repeat (4) @(negedge ref_clk);
    check({15'h0, irqReq}, 16'h0000);
    bus(1'b0, REQ_TWO_IDX, 8'h00);
    check(q, 16'h0008);
    bus(1'b1, EN_ONE_IDX, 8'h80);
    take(9, 2'h0);
    finish();
  endtask : t_global

  task automatic t_vectors();
    bus(1'b1, EN_ONE_IDX, 8'hBF);
    bus(1'b1, EN_TWO_IDX, 8'hB5);
    bus(1'b1, EN_THREE_IDX, 8'h0A);
    for (int s = 0; s < 12; s++) begin
      fire(s);
      if (!LVLSRC[s]) begin
        @(negedge ref_clk);
        check({15'h0, irqReq}, 16'h0000);
        @(negedge ref_clk);
        check({15'h0, irqReq}, 16'h0001);
      end
      take(s, 2'h0);
      finish();
    end
    // reload flag asks only under its own enable; both priority bits give level 3
    bus(1'b1, EN_TWO_IDX, 8'h35);
    bus(1'b1, PRIO_LO_IDX, 8'h20);
    bus(1'b1, PRIO_HI_IDX, 8'h20);
    @(posedge ref_clk);
    reloadEvt <= 1'b1;
    @(posedge ref_clk);
    reloadEvt <= 1'b0;
    bus(1'b0, REQ_ONE_IDX, 8'h00);
    check(q, 16'h0080);
    check({15'h0, irqReq}, 16'h0000);
    bus(1'b1, EN_TWO_IDX, 8'hB5);
    take(10, 2'h3);
    finish();
  endtask : t_vectors

  // a second reset in mid-run must read back zero at PRIO_HI_IDX and EN_ONE_IDX
  task automatic t_reset();
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    bus(1'b0, PRIO_HI_IDX, 8'h00);
    check(q, 16'h0000);
    bus(1'b0, EN_ONE_IDX, 8'h00);
    check(q, 16'h0000);
  endtask : t_reset

  // slow core: four requests pile up, then a higher level preempts a service
  task automatic t_prio();
    bus(1'b1, PRIO_LO_IDX, 8'h01);
    bus(1'b1, PRIO_HI_IDX, 8'h20);
    ackEnable <= 1'b0;
    ackWait <= 4'h3;
    @(posedge ref_clk);
    lvl <= 12'h041;
    evt <= 12'h202;
    @(posedge ref_clk);
    evt <= 12'h000;
    repeat (4) @(posedge ref_clk);
    ackEnable <= 1'b1;
    take(9, 2'h2);
    finish();
    take(0, 2'h1);
    finish();
    take(1, 2'h1);
    finish();
    take(6, 2'h0);
    finish();
    fire(6);
    take(6, 2'h0);
    fire(9);
    take(9, 2'h2);
    check({12'h0, inServiceLevels}, 16'h0005);
    finish();
    finish();
  endtask : t_prio

  initial begin
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_regs();
    t_global();
    t_vectors();
    t_prio();
    t_reset();
    conclude();
  end

  // a hang counts as a mismatch and still reaches the verdict
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    conclude();
  end
endmodule : flic_top_bench

bind flic_top flic_top_props props (
  .ref_clk(ref_clk),
  .arst_n(arst_n),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest),
  .irqAck(irqAck),
  .retiDone(retiDone),
  .irqReq(irqReq),
  .irqVector(irqVector),
  .irqLevel(irqLevel),
  .irqSource(irqSource),
  .inServiceLevels(inServiceLevels)
);
